// file: pkg/incexec_pkg.sv
// constants and carrier types for the increment / or-immediate execution block
package incexec_pkg;

    // ************************************************************
    // instruction encoding
    // ************************************************************
    localparam int          INSTR_W          = 14;
    localparam int          DATA_W           = 8;
    localparam int          ADDR_W           = 7;
    localparam int          OPC_MSB          = 13;
    localparam int          OPC_LSB          = 8;
    localparam int          DEST_BIT         = 7;
    localparam logic [5:0]  OPC_INC_SKIP     = 6'h0F;
    localparam logic [5:0]  OPC_INC_REG      = 6'h0A;
    localparam logic [5:0]  OPC_OR_IMM       = 6'h38;
    localparam logic        DEST_ACCUM       = 1'b0;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0]  ACCUM_RESET      = 8'h00;
    localparam logic        NULL_FLAG_RESET  = 1'b0;

    typedef enum logic [1:0]
    {
        OP_NONE,
        OP_INC_SKIP,
        OP_INC_REG,
        OP_OR_IMM
    } op_kind_t;

    // file register write request
    typedef struct packed
    {
        logic                  wr_en;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     data;
    } file_wr_t;

    // decoded instruction
    typedef struct packed
    {
        op_kind_t              kind;
        logic                  dest_file;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     imm;
    } decoded_t;

endpackage

// file: rtl/incexec_core.sv
// execution of increment-skip, increment and or-immediate instructions
`timescale 1ns/1ps
module incexec_core
    import incexec_pkg::*;
(
    // clock and reset
    input  wire logic               core_clk_in,
    input  wire logic               rst_in,
    // instruction stream
    input  wire logic               instr_valid_in,
    input  wire logic [INSTR_W-1:0] instr_in,
    // file register read data for the addressed register
    input  wire logic [DATA_W-1:0]  file_rd_data_in,
    // file register address and write request
    output logic [ADDR_W-1:0]       file_rd_addr_out,
    output file_wr_t                file_wr_out,
    // architectural state
    output logic [DATA_W-1:0]       accum_out,
    output logic                    null_flag_out,
    // sequencing
    output logic                    squash_out,
    output logic                    executed_out
);

    decoded_t           dec;
    logic [DATA_W-1:0]  inc_result;
    logic [DATA_W-1:0]  or_result;
    logic [DATA_W-1:0]  accum_reg;
    logic [DATA_W-1:0]  accum_next;
    logic               null_flag_reg;
    logic               null_flag_next;
    logic               squash_reg;
    logic               squash_next;
    logic               executing;
    file_wr_t           file_wr_reg;
    file_wr_t           file_wr_next;
    logic               executed_reg;

    // ************************************************************
    // decode and datapath
    // ************************************************************
    incexec_decode incexec_decode_inst
    (
        .instr_in (instr_in),
        .dec_out  (dec)
    );

    // a squashed slot runs as an idle op
    assign executing        = instr_valid_in && !squash_reg;
    assign file_rd_addr_out = dec.addr;
    assign inc_result       = file_rd_data_in + 8'h01;
    assign or_result        = accum_reg | dec.imm;

    always_comb
    begin
        accum_next          = accum_reg;
        null_flag_next      = null_flag_reg;
        squash_next         = 1'b0;
        file_wr_next.wr_en  = 1'b0;
        file_wr_next.addr   = dec.addr;
        file_wr_next.data   = inc_result;
        if (executing)
        begin
            unique case (dec.kind)
                OP_INC_SKIP:
                begin
                    if (dec.dest_file == DEST_ACCUM)
                    begin
                        accum_next = inc_result;
                    end
                    else
                    begin
                        file_wr_next.wr_en = 1'b1;
                    end
                    squash_next = (inc_result == 8'h00);
                end
                OP_INC_REG:
                begin
                    if (dec.dest_file == DEST_ACCUM)
                    begin
                        accum_next = inc_result;
                    end
                    else
                    begin
                        file_wr_next.wr_en = 1'b1;
                    end
                    null_flag_next = (inc_result == 8'h00);
                end
                OP_OR_IMM:
                begin
                    accum_next     = or_result;
                    null_flag_next = (or_result == 8'h00);
                end
                OP_NONE:
                begin
                end
            endcase
        end
    end

    // ************************************************************
    // state registers
    // ************************************************************
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            accum_reg <= ACCUM_RESET;
        end
        else
        begin
            accum_reg <= accum_next;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            null_flag_reg <= NULL_FLAG_RESET;
        end
        else
        begin
            null_flag_reg <= null_flag_next;
        end
    end

    // squash holds until the next valid slot has been consumed
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            squash_reg <= 1'b0;
        end
        else if (instr_valid_in)
        begin
            squash_reg <= squash_next;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            file_wr_reg <= '0;
        end
        else
        begin
            file_wr_reg <= file_wr_next;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            executed_reg <= 1'b0;
        end
        else
        begin
            executed_reg <= executing && (dec.kind != OP_NONE);
        end
    end

    assign accum_out     = accum_reg;
    assign null_flag_out = null_flag_reg;
    assign squash_out    = squash_reg;
    assign file_wr_out   = file_wr_reg;
    assign executed_out  = executed_reg;

    // ************************************************************
    // assertions
    // ************************************************************
    sequence inc_skip_zero_s;
        instr_valid_in && !squash_reg && dec.kind == OP_INC_SKIP
            && file_rd_data_in == 8'hFF;
    endsequence

    sequence idle_slot_s;
        squash_reg ##0 instr_valid_in;
    endsequence

    property skip_flag_p;
        @(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && !squash_reg && dec.kind == OP_INC_SKIP
            |=> null_flag_reg == $past(null_flag_reg);
    endproperty

    skip_no_flag_a: assert property (skip_flag_p)
        else $error("increment-skip changed the null flag");

    dest_accum_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && !squash_reg && dec.kind == OP_INC_REG && !dec.dest_file
            |=> accum_reg == $past(file_rd_data_in) + 8'h01 && !file_wr_reg.wr_en)
        else $error("increment to accumulator went wrong");

    dest_file_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && !squash_reg && dec.kind != OP_OR_IMM && dec.kind != OP_NONE
            && dec.dest_file
            |=> file_wr_reg.wr_en && file_wr_reg.addr == $past(dec.addr)
                && accum_reg == $past(accum_reg))
        else $error("file destination write missing");

    skip_squash_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        inc_skip_zero_s |=> squash_reg)
        else $error("zero result did not squash next word");

    idle_slot_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        idle_slot_s |=> !file_wr_reg.wr_en && accum_reg == $past(accum_reg)
            && !squash_reg && !executed_reg)
        else $error("squashed slot was not idle");

    inc_zero_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && !squash_reg && dec.kind == OP_INC_REG
            |=> null_flag_reg == ($past(file_rd_data_in) == 8'hFF))
        else $error("increment null flag wrong");

    or_result_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        instr_valid_in && !squash_reg && dec.kind == OP_OR_IMM
            |=> accum_reg == ($past(accum_reg) | $past(dec.imm))
                && null_flag_reg == (($past(accum_reg) | $past(dec.imm)) == 8'h00))
        else $error("or-immediate result wrong");

    flag_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !(instr_valid_in && !squash_reg && (dec.kind == OP_INC_REG || dec.kind == OP_OR_IMM))
            |=> $stable(null_flag_reg))
        else $error("null flag moved without a flag-setting instruction");

endmodule

// file: rtl/incexec_decode.sv
// instruction word decoder for the execution block
`timescale 1ns/1ps
module incexec_decode
    import incexec_pkg::*;
(
    // instruction word
    input  wire logic [INSTR_W-1:0] instr_in,
    // decoded fields
    output decoded_t                dec_out
);

    logic [5:0] opcode;

    assign opcode = instr_in[OPC_MSB:OPC_LSB];

    always_comb
    begin
        dec_out.dest_file = instr_in[DEST_BIT];
        dec_out.addr      = instr_in[ADDR_W-1:0];
        dec_out.imm       = instr_in[DATA_W-1:0];
        if (opcode == OPC_INC_SKIP)
        begin
            dec_out.kind = OP_INC_SKIP;
        end
        else if (opcode == OPC_INC_REG)
        begin
            dec_out.kind = OP_INC_REG;
        end
        else if (opcode == OPC_OR_IMM)
        begin
            dec_out.kind = OP_OR_IMM;
        end
        else
        begin
            dec_out.kind = OP_NONE;
        end
    end

endmodule

// file: verif/test_increment_or_literal_exec.sv
// self-checking bench for the increment / or-immediate execution block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module test_increment_or_literal_exec;
    import incexec_pkg::*;

    // ************************************************************
    // design hookup
    // ************************************************************
    logic                core_clk_in;
    logic                rst_in;
    logic                instr_valid_in;
    logic [INSTR_W-1:0]  instr_in;
    logic [DATA_W-1:0]   file_rd_data_in;
    logic [ADDR_W-1:0]   file_rd_addr_out;
    file_wr_t            file_wr_out;
    logic [DATA_W-1:0]   accum_out;
    logic                null_flag_out;
    logic                squash_out;
    logic                executed_out;
    int                  err_count = 0;
    int                  check_count = 0;
    int                  seed;
    // reference state and the slot sampled at the coming edge
    logic [7:0]          m_acc;
    logic                m_flag;
    logic                m_sq;
    logic                m_wr;
    logic                m_ex;
    logic [6:0]          m_wa;
    logic [7:0]          m_wd;
    logic                pv;
    logic [13:0]         pi;
    logic [7:0]          pd;
    logic [5:0]          ops [4];
    logic [13:0]         dir_i [12];
    logic [7:0]          dir_d [12];
    logic [12:0]         dir_v;

    incexec_core incexec_core_inst
    (
        .core_clk_in      (core_clk_in),
        .rst_in           (rst_in),
        .instr_valid_in   (instr_valid_in),
        .instr_in         (instr_in),
        .file_rd_data_in  (file_rd_data_in),
        .file_rd_addr_out (file_rd_addr_out),
        .file_wr_out      (file_wr_out),
        .accum_out        (accum_out),
        .null_flag_out    (null_flag_out),
        .squash_out       (squash_out),
        .executed_out     (executed_out)
    );

    initial
    begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end

    // ************************************************************
    // closing and watchdog
    // ************************************************************
    task final_report;
    begin
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask

    initial
    begin
        #(50 * 1000);
        err_count++;
        final_report();
    end

    // ************************************************************
    // one slot: drive, advance reference, compare
    // ************************************************************
    task step(input logic v, input logic [13:0] i, input logic [7:0] d);
        logic [7:0] r;
    begin
        @(posedge core_clk_in);
        instr_valid_in  <= v;
        instr_in        <= i;
        file_rd_data_in <= d;
        m_wr = 1'b0;
        m_ex = 1'b0;
        r = pd + 8'h01;
        if (pv && m_sq)
            m_sq = 1'b0;
        else if (pv)
        begin
            case (pi[13:8])
                OPC_INC_SKIP, OPC_INC_REG:
                begin
                    m_ex = 1'b1;
                    if (pi[DEST_BIT])
                    begin
                        m_wr = 1'b1;
                        m_wa = pi[6:0];
                        m_wd = r;
                    end
                    else
                        m_acc = r;
                    if (pi[13:8] == OPC_INC_SKIP)
                        m_sq = (r == 8'h00);
                    else
                        m_flag = (r == 8'h00);
                end
                OPC_OR_IMM:
                begin
                    m_ex = 1'b1;
                    m_acc = m_acc | pi[7:0];
                    m_flag = (m_acc == 8'h00);
                end
                default: ;
            endcase
        end
        pv = v;
        pi = i;
        pd = d;
        @(negedge core_clk_in);
        `CHK("accum", m_acc, accum_out)
        `CHK("null_flag", m_flag, null_flag_out)
        `CHK("squash", m_sq, squash_out)
        `CHK("executed", m_ex, executed_out)
        `CHK("wr_en", m_wr, file_wr_out.wr_en)
        if (m_wr)
        begin
            `CHK("wr_addr", m_wa, file_wr_out.addr)
            `CHK("wr_data", m_wd, file_wr_out.data)
        end
        `CHK("rd_addr", i[6:0], file_rd_addr_out)
    end
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        rst_in = 1'b1;
        instr_valid_in = 1'b0;
        instr_in = 14'h0000;
        file_rd_data_in = 8'h00;
        seed = 60285;
        pv = 1'b0;
        pi = 14'h0000;
        pd = 8'h00;
        m_acc = ACCUM_RESET;
        m_flag = NULL_FLAG_RESET;
        m_sq = 1'b0;
        ops = '{OPC_INC_SKIP, OPC_INC_REG, OPC_OR_IMM, 6'h3F};
        // skip with gap, skipped slot, d=0 paths, wrap, skip over an increment, unknown op
        dir_i = '{14'h0F90, 14'h3835, 14'h38FF, 14'h0F05, 14'h3835, 14'h0A85,
                  14'h0A00, 14'h0F00, 14'h0A00, 14'h3F12, 14'h3800, 14'h0F7F};
        dir_d = '{8'hFF, 8'h00, 8'h00, 8'h99, 8'h00, 8'hFF,
                  8'hFF, 8'hFF, 8'h10, 8'h00, 8'h00, 8'h41};
        dir_v = 13'h0FFD;
        repeat (12) @(posedge core_clk_in);
        `CHK("reset_accum", ACCUM_RESET, accum_out)
        `CHK("reset_flag", NULL_FLAG_RESET, null_flag_out)
        `CHK("reset_squash", 1'b0, squash_out)
        rst_in <= 1'b0;
        for (int n = 0; n < 12; n++)
            step(dir_v[n], dir_i[n], dir_d[n]);
        step(1'b0, 14'h0000, 8'h00);
        $display("test directed done, mismatches %0d", err_count);
        for (int n = 0; n < 400; n++)
        begin
            logic [31:0] k;
            k = $random(seed);
            step(k[31:30] != 2'b00, {ops[k[1:0]], k[15:8]}, k[9] ? 8'hFF : k[23:16]);
        end
        step(1'b0, 14'h0000, 8'h00);
        $display("test random done, mismatches %0d", err_count);
        final_report();
    end
endmodule
